//--- core/ica_channel_alarm.sv
// four-channel configuration store and alarm evaluator behind an apb slave
// assumes measurements in signed q16.16 display units from logic on i_clk,
// and sensor fault flags from pins outside the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ica_params.svh"

// Summary of operation
// - user curve index takes 0 to 3, selecting that curve for the channel
// - curve index query answers minus one when the stored index exceeds 3
// - legacy sensor index is written by host and read back unchanged
// - legacy index zero means no sensor; readings on that channel suppressed
// - alarm status reads two characters: --, SF, HI or LO
// - high and low alarms carry a quarter kelvin hysteresis band in K, C and F units; raw units get 0.25 V or ohm
// - alarms compare the filtered temperature, not the raw sample
// - filtered temperature above enabled high set point raises high alarm
// - filtered temperature below enabled low set point raises low alarm
// - set points are taken and reported in the channel display units
// - set points are stored and returned as full 32-bit floats
// - each alarm has its own enable; disabled alarm never asserts
// - enables are written and read as keywords yes or no
// - chained queries are answered in order, one answer per access
// - shortened keywords map to the same register as full ones
// - excitation level is one of 1 V, 10 mV, 3.33 mV or 1 mV
// - excitation query on a non constant-voltage sensor answers n/a
// - number, tag and letter forms all select the same channel
// - display filter time constant selects 0.5 s to 64 s by powers of two
// - units are K, C, F or raw; raw reads as volts or ohms by sensor type
module ica_channel_alarm (
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [3:0]            i_meas_stb,
    input  wire ica_pkg::ica_words_t   i_meas_temp,
    input  wire logic [3:0]            i_sensor_fault,
    output ica_pkg::ica_words_t        o_temp,
    output logic      [3:0]            o_temp_valid,
    output logic      [3:0]            o_alarm_hi,
    output logic      [3:0]            o_alarm_lo,
    output ica_pkg::ica_bytes_t        o_curve_sel,
    output logic      [7:0]            o_excitation_voltage_setting_sel
);

    // float set point to signed q16.16; magnitudes past 2^15 saturate
    function automatic logic [31:0] f2q(input logic [31:0] f);
        logic [31:0] mag;
        logic [31:0] q;
        mag = {8'h00, 1'b1, f[22:0]};
        if (f[30:23] < 8'd111)
            q = 32'h00000000;
        else if (f[30:23] > 8'd141)
            q = 32'h7fffffff;
        else if (f[30:23] >= 8'd134)
            q = mag << (f[30:23] - 8'd134);
        else
            q = mag >> (8'd134 - f[30:23]);
        f2q = f[31] ? (32'h00000000 - q) : q;
    endfunction : f2q

    // keyword to enable bit; anything else keeps the old setting
    function automatic logic kw_en(input logic [31:0] w, input logic old);
        if (w == `ICA_KW_YES)
            kw_en = 1'b1;
        else if (w == `ICA_KW_NO)
            kw_en = 1'b0;
        else
            kw_en = old;
    endfunction : kw_en

    function automatic logic [31:0] en_kw(input logic e);
        en_kw = e ? `ICA_KW_YES : `ICA_KW_NO;
    endfunction : en_kw

    ica_pkg::ica_bytes_t  curve_reg, curve_next;
    ica_pkg::ica_bytes_t  legacy_reg, legacy_next;
    ica_pkg::ica_bytes_t  factory_reg, factory_next;
    logic [3:0][1:0]      units_reg, units_next;
    logic [3:0]           cv_reg, cv_next;
    logic [3:0][1:0]      excitation_voltage_setting_reg, excitation_voltage_setting_next;
    ica_pkg::ica_words_t  hisp_reg, hisp_next;
    ica_pkg::ica_words_t  losp_reg, losp_next;
    logic [3:0]           hien_reg, hien_next;
    logic [3:0]           loen_reg, loen_next;
    logic [2:0]           filt_reg, filt_next;
    ica_pkg::ica_words_t  flt_reg, flt_next;
    logic [3:0]           ahi_reg, ahi_next;
    logic [3:0]           alo_reg, alo_next;
    logic [3:0]           sf_meta_reg, sf_reg;
    logic [31:0]          prdata_reg, prdata_next;
    logic                 pready_reg, pready_next;
    logic                 pslverr_reg, pslverr_next;

    logic       setup;
    logic       wr;
    logic [1:0] ch;
    logic [5:0] ofs;
    logic       glob;

    // channel comes from two address bits whatever form the host used
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite & pready_reg;
    assign ch    = paddr[7:6];
    assign ofs   = paddr[5:0];
    assign glob  = paddr[8];

    // configuration writes; all land on the access edge only
    always_comb
    begin
        curve_next   = curve_reg;
        legacy_next  = legacy_reg;
        factory_next = factory_reg;
        units_next   = units_reg;
        cv_next      = cv_reg;
        excitation_voltage_setting_next   = excitation_voltage_setting_reg;
        hisp_next    = hisp_reg;
        losp_next    = losp_reg;
        hien_next    = hien_reg;
        loen_next    = loen_reg;
        filt_next    = filt_reg;
        if (wr && glob && paddr == `ICA_OFS_FILTER)
            filt_next = pwdata[2:0];
        if (wr && paddr[11:8] == 4'h0)
        begin
            unique case (ofs)
                `ICA_OFS_CURVE:   curve_next[ch] = pwdata[7:0];
                `ICA_OFS_LEGACY:  legacy_next[ch] = pwdata[7:0];
                `ICA_OFS_FACTORY: factory_next[ch] = pwdata[7:0];
                `ICA_OFS_UNITS:
                begin
                    units_next[ch] = pwdata[1:0];
                    cv_next[ch]    = pwdata[`ICA_UNITS_CV_BIT];
                end
                `ICA_OFS_HISP:    hisp_next[ch] = pwdata;
                `ICA_OFS_LOSP:    losp_next[ch] = pwdata;
                `ICA_OFS_HIEN:    hien_next[ch] = kw_en(pwdata, hien_reg[ch]);
                `ICA_OFS_LOEN:    loen_next[ch] = kw_en(pwdata, loen_reg[ch]);
                `ICA_OFS_EXCITATION_VOLTAGE_SETTING:   excitation_voltage_setting_next[ch] = pwdata[1:0];
                default:          ;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            curve_reg   <= {4{`ICA_RST_IDX}};
            legacy_reg  <= {4{`ICA_RST_IDX}};
            factory_reg <= {4{`ICA_RST_IDX}};
            units_reg   <= {4{`ICA_RST_UNITS}};
            cv_reg      <= 4'h0;
            excitation_voltage_setting_reg   <= {4{`ICA_RST_EXCITATION_VOLTAGE_SETTING}};
            hisp_reg    <= {4{`ICA_RST_SP}};
            losp_reg    <= {4{`ICA_RST_SP}};
            hien_reg    <= 4'h0;
            loen_reg    <= 4'h0;
            filt_reg    <= `ICA_RST_FILTER;
        end
        else
        begin
            curve_reg   <= curve_next;
            legacy_reg  <= legacy_next;
            factory_reg <= factory_next;
            units_reg   <= units_next;
            cv_reg      <= cv_next;
            excitation_voltage_setting_reg   <= excitation_voltage_setting_next;
            hisp_reg    <= hisp_next;
            losp_reg    <= losp_next;
            hien_reg    <= hien_next;
            loen_reg    <= loen_next;
            filt_reg    <= filt_next;
        end
    end

    // fault pins are asynchronous; only the second stage is read
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sf_meta_reg <= 4'h0;
            sf_reg      <= 4'h0;
        end
        else
        begin
            sf_meta_reg <= i_sensor_fault;
            sf_reg      <= sf_meta_reg;
        end
    end

    // first-order filter per channel; shift of code+1 doubles the time
    // constant per step, assuming one sample strobe per quarter second
    always_comb
    begin
        logic [32:0] diff;
        diff     = 33'h000000000;
        flt_next = flt_reg;
        for (int i = 0; i < 4; i++)
        begin
            diff = {i_meas_temp[i][31], i_meas_temp[i]} - {flt_reg[i][31], flt_reg[i]};
            if (i_meas_stb[i])
                flt_next[i] = flt_reg[i]
                    + 32'($signed(diff) >>> ({1'b0, filt_reg} + 4'h1));
        end
    end

    // hysteresis held in display units; fahrenheit widens it to 0.45
    always_comb
    begin
        logic signed [31:0] t;
        logic signed [31:0] hs;
        logic signed [31:0] ls;
        logic signed [31:0] hy;
        t  = 32'sh00000000;
        hs = 32'sh00000000;
        ls = 32'sh00000000;
        hy = 32'sh00000000;
        ahi_next = ahi_reg;
        alo_next = alo_reg;
        for (int i = 0; i < 4; i++)
        begin
            t  = flt_reg[i];
            hs = f2q(hisp_reg[i]);
            ls = f2q(losp_reg[i]);
            hy = (units_reg[i] == ica_pkg::UNITS_F) ? `ICA_HYST_F : `ICA_HYST_KC;
            if (!hien_reg[i] || legacy_reg[i] == 8'h00)
                ahi_next[i] = 1'b0;
            else if (!ahi_reg[i])
                ahi_next[i] = (t > hs);
            else
                ahi_next[i] = !(t < hs - hy);
            if (!loen_reg[i] || legacy_reg[i] == 8'h00)
                alo_next[i] = 1'b0;
            else if (!alo_reg[i])
                alo_next[i] = (t < ls);
            else
                alo_next[i] = !(t > ls + hy);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            flt_reg <= {4{32'h00000000}};
            ahi_reg <= 4'h0;
            alo_reg <= 4'h0;
        end
        else
        begin
            flt_reg <= flt_next;
            ahi_reg <= ahi_next;
            alo_reg <= alo_next;
        end
    end

    // read word for one channel register; sensor fault beats alarms
    function automatic logic [31:0] rd_chan(input logic [1:0] c, input logic [5:0] o);
        logic [31:0] w;
        logic [7:0]  u;
        w = 32'h00000000;
        unique case (units_reg[c])
            ica_pkg::UNITS_K: u = `ICA_CH_K;
            ica_pkg::UNITS_C: u = `ICA_CH_C;
            ica_pkg::UNITS_F: u = `ICA_CH_F;
            ica_pkg::UNITS_S: u = cv_reg[c] ? `ICA_CH_V : `ICA_CH_O;
        endcase
        unique case (o)
            `ICA_OFS_CURVE:
                w = (curve_reg[c] > `ICA_CURVE_MAX) ? `ICA_MINUS_ONE
                    : {24'h000000, curve_reg[c]};
            `ICA_OFS_LEGACY:  w = {24'h000000, legacy_reg[c]};
            `ICA_OFS_FACTORY: w = {24'h000000, factory_reg[c]};
            `ICA_OFS_UNITS:   w = {23'h000000, cv_reg[c], u};
            `ICA_OFS_HISP:    w = hisp_reg[c];
            `ICA_OFS_LOSP:    w = losp_reg[c];
            `ICA_OFS_HIEN:    w = en_kw(hien_reg[c]);
            `ICA_OFS_LOEN:    w = en_kw(loen_reg[c]);
            `ICA_OFS_EXCITATION_VOLTAGE_SETTING:
                w = cv_reg[c] ? {30'h00000000, excitation_voltage_setting_reg[c]} : `ICA_KW_NA;
            `ICA_OFS_ALARM:
                if (sf_reg[c])
                    w = {16'h0000, `ICA_CODE_SF};
                else if (ahi_reg[c])
                    w = {16'h0000, `ICA_CODE_HI};
                else if (alo_reg[c])
                    w = {16'h0000, `ICA_CODE_LO};
                else
                    w = {16'h0000, `ICA_CODE_NONE};
            `ICA_OFS_TEMP:    w = (legacy_reg[c] == 8'h00) ? 32'h00000000 : flt_reg[c];
            default:          w = 32'h00000000;
        endcase
        rd_chan = w;
    endfunction : rd_chan

    // answer is prepared at setup so the access phase never waits;
    // each access answers one query, so chained queries keep their order
    always_comb
    begin
        logic bad;
        bad          = 1'b0;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = setup;
        if (setup)
        begin
            if (paddr[1:0] != 2'h0 || paddr[11:9] != 3'h0)
                bad = 1'b1;
            else if (glob)
                bad = (paddr != `ICA_OFS_FILTER);
            else
                bad = (ofs > `ICA_OFS_TEMP);
            pslverr_next = bad;
            if (bad)
                prdata_next = 32'h00000000;
            else if (glob)
                prdata_next = {29'h00000000, filt_reg};
            else
                prdata_next = rd_chan(ch, ofs);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // outputs straight from flops; absent sensors show no reading
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            o_temp[i]       = (legacy_reg[i] == 8'h00) ? 32'h00000000 : flt_reg[i];
            o_temp_valid[i] = (legacy_reg[i] != 8'h00);
            o_excitation_voltage_setting_sel[2*i +: 2] = excitation_voltage_setting_reg[i];
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign o_alarm_hi  = ahi_reg;
    assign o_alarm_lo  = alo_reg;
    assign o_curve_sel = curve_reg;

endmodule : ica_channel_alarm
`default_nettype wire

//--- include/ica_params.svh
// constants of the input channel alarm and configuration block
// assumes a 12-bit apb byte address; four channels of 0x40 bytes each
`ifndef ICA_PARAMS_SVH
`define ICA_PARAMS_SVH
`define ICA_OFS_CURVE   6'h00
`define ICA_OFS_LEGACY  6'h04
`define ICA_OFS_FACTORY 6'h08
`define ICA_OFS_UNITS   6'h0c
`define ICA_OFS_HISP    6'h10
`define ICA_OFS_LOSP    6'h14
`define ICA_OFS_HIEN    6'h18
`define ICA_OFS_LOEN    6'h1c
`define ICA_OFS_EXCITATION_VOLTAGE_SETTING   6'h20
`define ICA_OFS_ALARM   6'h24
`define ICA_OFS_TEMP    6'h28
`define ICA_OFS_FILTER  12'h100
`define ICA_UNITS_CV_BIT 8
`define ICA_RST_IDX     8'h00
`define ICA_RST_UNITS   2'h0
`define ICA_RST_EXCITATION_VOLTAGE_SETTING   2'h0
`define ICA_RST_FILTER  3'h3
`define ICA_RST_SP      32'h00000000
`define ICA_CURVE_MAX   8'h03
`define ICA_MINUS_ONE   32'hffffffff
`define ICA_KW_YES      32'h00594553
`define ICA_KW_NO       32'h00004e4f
`define ICA_KW_NA       32'h004e2f41
`define ICA_CODE_SF     16'h5346
`define ICA_CODE_HI     16'h4849
`define ICA_CODE_LO     16'h4c4f
`define ICA_CODE_NONE   16'h2d2d
`define ICA_CH_K        8'h4b
`define ICA_CH_C        8'h43
`define ICA_CH_F        8'h46
`define ICA_CH_V        8'h56
`define ICA_CH_O        8'h4f
`define ICA_HYST_KC     32'h00004000
`define ICA_HYST_F      32'h00007333
`endif

//--- include/ica_pkg.sv
// types shared by the channel alarm block and its bench
// assumes nothing beyond the params header for numbers
package ica_pkg;
    typedef enum logic [1:0] {
        UNITS_K = 2'h0,
        UNITS_C = 2'h1,
        UNITS_F = 2'h2,
        UNITS_S = 2'h3
    } ica_units_t;
    typedef enum logic [1:0] {
        VB_1V   = 2'h0,
        VB_10MV = 2'h1,
        VB_3MV3 = 2'h2,
        VB_1MV  = 2'h3
    } ica_excitation_voltage_setting_t;
    typedef logic [3:0][31:0] ica_words_t;
    typedef logic [3:0][7:0]  ica_bytes_t;
endpackage : ica_pkg

//--- test/ica_channel_alarm_sva.sv
// concurrent checks on the ports of the channel alarm block
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "ica_params.svh"
module ica_channel_alarm_sva (
    input wire logic                i_clk,
    input wire logic                i_sys_rst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire ica_pkg::ica_words_t o_temp,
    input wire logic [3:0]          o_temp_valid,
    input wire logic [3:0]          o_alarm_hi,
    input wire logic [3:0]          o_alarm_lo,
    input wire ica_pkg::ica_bytes_t o_curve_sel
);
    logic       leak;
    logic [1:0] ch_q;
    logic [7:0] wd_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // a channel without a sensor must read back as zero
    always_comb
    begin
        leak = 1'b0;
        for (int i = 0; i < 4; i++)
            leak = leak | (!o_temp_valid[i] && o_temp[i] != 32'h0);
    end
    // channel and data of the last transfer, for the curve check
    always_ff @(posedge i_clk)
    begin
        ch_q <= paddr[7:6];
        wd_q <= pwdata[7:0];
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_setup_answer: assert property (s_setup |=> pready)
        else $error("no answer in the cycle after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    a_err_nodata: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    a_rst_quiet: assert property (disable iff (1'b0) i_sys_rst |=>
        !pready && o_alarm_hi == 4'h0 && o_alarm_lo == 4'h0)
        else $error("outputs active after reset");
    a_no_sensor: assert property (!leak)
        else $error("reading shown on a channel without sensor");
    a_hi_needs_sensor: assert property (1'b1 |=> (o_alarm_hi & ~$past(o_temp_valid)) == 4'h0)
        else $error("high alarm on a channel without sensor");
    a_lo_needs_sensor: assert property (1'b1 |=> (o_alarm_lo & ~$past(o_temp_valid)) == 4'h0)
        else $error("low alarm on a channel without sensor");
    a_curve_write: assert property (s_access ##0 (pwrite && paddr[11:8] == 4'h0
        && paddr[5:0] == 6'h00 && pwdata <= 32'h3) |=> o_curve_sel[ch_q] == wd_q)
        else $error("curve select does not follow the written index");
    a_hi_off_clears: assert property (s_access ##0 (pwrite && paddr == 12'h018
        && pwdata == `ICA_KW_NO) |-> ##2 !o_alarm_hi[0])
        else $error("high alarm kept after disable");
    a_lo_off_clears: assert property (s_access ##0 (pwrite && paddr == 12'h01c
        && pwdata == `ICA_KW_NO) |-> ##2 !o_alarm_lo[0])
        else $error("low alarm kept after disable");
endmodule : ica_channel_alarm_sva
bind ica_channel_alarm ica_channel_alarm_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_temp(o_temp),
    .o_temp_valid(o_temp_valid), .o_alarm_hi(o_alarm_hi), .o_alarm_lo(o_alarm_lo),
    .o_curve_sel(o_curve_sel));
`default_nettype wire

//--- test/ica_channel_alarm_tb.sv
// self-checking bench for the channel alarm block
// assumes the host model drives apb; the bench drives samples and fault pins
`timescale 1ns/1ps
`default_nettype none
`include "ica_params.svh"
module ica_channel_alarm_tb;
    logic                i_clk;
    logic                i_sys_rst;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic                pready;
    logic                pslverr;
    logic [11:0]         paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic [3:0]          i_meas_stb;
    ica_pkg::ica_words_t i_meas_temp;
    logic [3:0]          i_sensor_fault;
    ica_pkg::ica_words_t o_temp;
    logic [3:0]          o_temp_valid;
    logic [3:0]          o_alarm_hi;
    logic [3:0]          o_alarm_lo;
    ica_pkg::ica_bytes_t o_curve_sel;
    logic [7:0]          o_excitation_voltage_setting_sel;
    logic signed [31:0]  f_exp;
    int                  miscompares;
    int                  compares;
    ica_host_model host (.i_clk(i_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ica_channel_alarm DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .i_meas_stb(i_meas_stb),
        .i_meas_temp(i_meas_temp), .i_sensor_fault(i_sensor_fault), .o_temp(o_temp),
        .o_temp_valid(o_temp_valid), .o_alarm_hi(o_alarm_hi), .o_alarm_lo(o_alarm_lo),
        .o_curve_sel(o_curve_sel), .o_excitation_voltage_setting_sel(o_excitation_voltage_setting_sel));
    // 50 mhz clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // hang guard: a stuck run still ends with a verdict
    initial
    begin
        repeat (100000) @(posedge i_clk);
        miscompares++;
        end_of_test();
    end
    task automatic end_of_test;
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic to;
        host.xfer(w, a, d, r, e, to);
        if (to)
        begin
            miscompares++;
            end_of_test();
        end
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        bus(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        bus(1'b0, a, 32'h0, r, e);
        cmp(what, exp, r);
    endtask : rd
    // forty samples on channel 0; the model halves the gap as filter code 0 does
    task automatic feed(input logic signed [31:0] x);
        repeat (40)
        begin
            i_meas_temp[0] <= x;
            i_meas_stb     <= 4'h1;
            @(posedge i_clk);
            f_exp = f_exp + ((x - f_exp) >>> 1);
        end
        i_meas_stb <= 4'h0;
        @(posedge i_clk);
        cmp("temp", f_exp, o_temp[0]);
    endtask : feed
    // main sequence: channel 1 curve, channel 2 units and bias, channel 0 alarms
    initial
    begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  uc [3];
        uc = '{`ICA_CH_K, `ICA_CH_C, `ICA_CH_F};
        i_sys_rst = 1'b1;
        i_meas_stb = 4'h0;
        i_meas_temp = '0;
        i_sensor_fault = 4'h0;
        f_exp = 32'sh0;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        rd("hi_en", 12'h018, `ICA_KW_NO);
        cmp("alarms", 32'h0, {24'h0, o_alarm_hi, o_alarm_lo});
        cmp("valid", 32'h0, {28'h0, o_temp_valid});
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h040, 32'(i));
            rd("curve", 12'h040, 32'(i));
            cmp("curve_sel", 32'(i), {24'h0, o_curve_sel[1]});
        end
        wr(12'h040, 32'h4);
        rd("curve_bad", 12'h040, `ICA_MINUS_ONE);
        bus(1'b0, 12'h02c, 32'h0, r, e);
        cmp("slverr", 32'h1, {31'h0, e});
        cmp("unmapped", 32'h0, r);
        wr(12'h08c, 32'h100);  // constant-voltage sensor on channel 2
        for (int v = 0; v < 4; v++)
        begin
            wr(12'h0a0, 32'(v));
            rd("excitation_voltage_setting", 12'h0a0, 32'(v));
            cmp("excitation_voltage_setting_sel", 32'(v), {30'h0, o_excitation_voltage_setting_sel[5:4]});
        end
        for (int u = 0; u < 3; u++)
        begin
            wr(12'h08c, 32'(u));
            rd("units", 12'h08c, {24'h0, uc[u]});
        end
        rd("excitation_voltage_setting_na", 12'h0a0, `ICA_KW_NA);
        wr(12'h010, 32'h4348d70a);
        rd("hi_sp", 12'h010, 32'h4348d70a);
        wr(12'h010, 32'h41200000);  // high set point 10.0 kelvin
        wr(12'h014, 32'h40a00000);  // low set point 5.0 kelvin
        wr(12'h004, 32'h7);
        rd("legacy", 12'h004, 32'h7);
        rd("filter_rst", 12'h100, 32'h3);
        wr(12'h100, 32'h0);
        rd("filter", 12'h100, 32'h0);
        wr(12'h008, 32'h5);
        rd("factory", 12'h008, 32'h5);
        feed(32'sh00070000);
        rd("status", 12'h024, {16'h0, `ICA_CODE_NONE});
        feed(32'sh000b0000);
        cmp("hi_off", 32'h0, {31'h0, o_alarm_hi[0]});
        wr(12'h018, `ICA_KW_YES);
        rd("hi_en", 12'h018, `ICA_KW_YES);
        rd("status", 12'h024, {16'h0, `ICA_CODE_HI});
        feed(32'sh0009e000);  // 9.875 sits inside the quarter band
        rd("status", 12'h024, {16'h0, `ICA_CODE_HI});
        feed(32'sh0009a000);
        rd("status", 12'h024, {16'h0, `ICA_CODE_NONE});
        feed(32'sh000b0000);
        i_sensor_fault <= 4'h1;
        repeat (3) @(posedge i_clk);
        rd("status", 12'h024, {16'h0, `ICA_CODE_SF});
        cmp("hi_kept", 32'h1, {31'h0, o_alarm_hi[0]});
        i_sensor_fault <= 4'h0;
        wr(12'h01c, `ICA_KW_YES);
        feed(32'sh00040000);
        rd("status", 12'h024, {16'h0, `ICA_CODE_LO});
        wr(12'h01c, 32'h12345678);
        rd("lo_en", 12'h01c, `ICA_KW_YES);
        wr(12'h01c, `ICA_KW_NO);
        wr(12'h018, `ICA_KW_NO);
        rd("status", 12'h024, {16'h0, `ICA_CODE_NONE});
        cmp("lo_off", 32'h0, {31'h0, o_alarm_lo[0]});
        wr(12'h004, 32'h0);
        cmp("no_sensor", 32'h0, o_temp[0]);
        end_of_test();
    end
endmodule : ica_channel_alarm_tb
`default_nettype wire

//--- test/ica_host_model.sv
// host side model: issues one apb transfer per command or query
// assumes the caller enters its task just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module ica_host_model (
    input  wire logic        i_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // idle bus at time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end
    // channel in address bits, set points as float words, enables as keywords
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic to);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r  = prdata;
        e  = pslverr;
        to = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;  // released lines do not keep the old value
        pwdata  <= ~d;
        @(posedge i_clk);
    endtask : xfer
endmodule : ica_host_model
`default_nettype wire
